/* led_grayscale_serial_frontend_bench.sv */
// Bench: sender and driver front end joined by the link, checked
// against a frame model. Assumes design files compiled first.
`timescale 1ns/1ps
module led_grayscale_serial_frontend_bench;
  logic mclk;
  logic resetn;
  logic start;
  logic [207:0] frame;
  logic ready;
  logic done;
  logic level_clock_in;
  logic [15:0] control_word;
  logic edge_fast;
  logic [1:0] resolution_sel;
  logic [4:0] level_depth;
  logic [3:0] prescale_shift;
  logic adaptive_density_waveform;
  logic segmented_pulse_waveform;
  logic ext_clock_sel;
  logic output_inverted;
  logic counter_restart;
  logic single_frame;
  logic [191:0] levels;
  logic latch_load;
  logic level_clock_out;
  logic level_tick;
  int mismatches;
  int samples_checked;
  int cycles;
  int loads;
  logic [207:0] exp_q[$];
  lgsf_link_if link_i ();
  lgsf_host #(.START_CYC(40)) lgsf_host_inst (.mclk, .resetn, .link(link_i.host), .start, .frame, .ready, .done);
  lgsf_device #(.START_CYC(40)) lgsf_device_inst (.mclk, .resetn, .link(link_i.dev), .level_clock_in,
    .control_word, .edge_fast, .resolution_sel, .level_depth, .prescale_shift, .adaptive_density_waveform,
    .segmented_pulse_waveform, .ext_clock_sel, .output_inverted, .counter_restart, .single_frame, .levels,
    .latch_load, .level_clock_out, .level_tick);
  lgsf_link_properties #(.START_CYC(40)) lgsf_link_properties_inst (.mclk, .resetn,
    .shift_clock_in(link_i.shift_clock_in), .serial_in(link_i.serial_in),
    .serial_out(link_i.serial_out), .shift_clock_out(link_i.shift_clock_out));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Ceiling well above ten frames of about 1700 cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (latch_load === 1'b1)
      loads <= loads + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      final_report();
    end
  end
  always @(negedge mclk)
    if (cycles % 4 == 0)
      level_clock_in <= ~level_clock_in;
  task automatic compare_value(input logic [191:0] got, input logic [191:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare_value
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Frames over every depth and prescale code
  // ----------------------------------------
  initial
  begin
    logic [15:0] c;
    logic [207:0] e;
    int d;
    int n;
    logic lco;
    resetn = 1'b0;
    start = 1'b0;
    frame = '0;
    level_clock_in = 1'b0;
    cycles = 0;
    loads = 0;
    void'($urandom(16));
    exp_q.push_back('0);
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      c = 16'($urandom);
      c[9:5] = {i[1:0], i[2:0]};
      if (i < 8)
        c[3] = 1'b0;
      // Last bit low so the retimed pulses start from low
      frame = {c, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom & 32'hfffffffe};
      e = frame;
      d = (c[9:8] == 2'h0) ? 8 : 10 + 2 * c[9:8];
      e[207:203] = 5'h00;
      if (c[3])
        e[199:197] = 3'h0;
      for (int k = 0; k < 12; k++)
        e[16 * k +: 16] &= 16'hffff >> (16 - d);
      exp_q.push_back(e);
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      repeat (600) @(negedge mclk);
      compare_value(levels, exp_q[0][191:0]);
      compare_value(control_word, exp_q[0][207:192]);
      compare_value(ready, 1'b0);
      n = 0;
      while (done !== 1'b1 && n < 3000)
      begin
        @(negedge mclk);
        n++;
      end
      compare_value(done, 1'b1);
      repeat (4) @(negedge mclk);
      void'(exp_q.pop_front());
      e = exp_q[0];
      compare_value(levels, e[191:0]);
      compare_value(control_word, e[207:192]);
      compare_value(loads, i + 1);
      compare_value({edge_fast, resolution_sel, level_depth}, {e[202], e[201:200], 5'(d)});
      compare_value({prescale_shift, adaptive_density_waveform, segmented_pulse_waveform, ext_clock_sel,
        output_inverted, counter_restart, single_frame}, {4'((e[199:197] < 5) ? e[199:197] : e[199:197] + 1),
        e[196], ~e[196], e[195], e[194], e[193] & e[195], e[192] & e[193] & e[195]});
      compare_value(ready, 1'b1);
      // Grayscale tick spacing: external clock edges every 4 cycles, internal 6 cycles times the divisor
      n = 0;
      while (level_tick !== 1'b1 && n < 4000)
      begin
        @(negedge mclk);
        n++;
      end
      lco = level_clock_out;
      n = 0;
      do
      begin
        @(negedge mclk);
        n++;
      end
      while (level_tick !== 1'b1 && n < 4000);
      compare_value(n, e[195] ? 4 : 6 << ((e[199:197] < 5) ? e[199:197] : e[199:197] + 1));
      compare_value(level_clock_out, !lco);
    end
    final_report();
  end
endmodule : led_grayscale_serial_frontend_bench

/* lgsf_device.sv */
// Driver-side serial front end: double-edge shift register, cascade
// output, latch sequence detection, holding latch and control decode.
// Assumes link pins are synchronous to mclk and change at most once a cycle.
//
// Contract
// RL1 - Sample serial input on both shift clock edges
// RL2 - Shift 208 bits, latch only on sequence
// RL3 - Pass leaving bits out on every edge
// RL4 - Frame is control word plus twelve levels
// RL5 - Control word sits in frame bits 207:192
// RL6 - Sender zeroes unused control bits 15:11
// RL7 - Edge rate bit selects slow or fast
// RL8 - Resolution field selects 8/12/14/16 bit depth
// RL9 - Prescale field divides internal clock by table
// RL10 - Sender zeroes prescale when external clock used
// RL11 - Waveform bit selects segmented or density waveform
// RL12 - Source bit selects internal or external clock
// RL13 - Sense bit selects sink or inverted generator
// RL14 - Counter restart only with external clock
// RL15 - Single frame only with counter restart
// RL16 - Channel levels follow, first channel highest, MSB first
// RL17 - Sender right-justifies levels, zeroes upper bits
// RL18 - Latch pulses high 70ns, low 230ns minimum
// RL19 - Stop interval exceeds 200ns plus 10ns per device
// RL20 - Quiet shift clock over 220us starts latch
// RL21 - Four pulses, latch on second falling edge
// RL22 - Regenerate latch pulses 90ns wide on output
// RL23 - Settings change only when latch loads
`timescale 1ns/1ps
`include "lgsf_map.svh"
module lgsf_device #(
  parameter int START_CYC = (`LGSF_START_TIME_US * `LGSF_NS_PER_US) / `LGSF_CLK_PERIOD_NS + 1,
  parameter int RETIME_CYC = `LGSF_RETIME_NS / `LGSF_CLK_PERIOD_NS,
  parameter int OSC_HALF_CYC = `LGSF_OSC_HALF_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  lgsf_link_if.dev link,
  input wire logic level_clock_in,
  output logic [`LGSF_WORD_BITS-1:0] control_word,
  output logic edge_fast,
  output logic [1:0] resolution_sel,
  output logic [4:0] level_depth,
  output logic [3:0] prescale_shift,
  output logic adaptive_density_waveform,
  output logic segmented_pulse_waveform,
  output logic ext_clock_sel,
  output logic output_inverted,
  output logic counter_restart,
  output logic single_frame,
  output logic [`LGSF_LEVEL_MSB:0] levels,
  output logic latch_load,
  output logic level_clock_out,
  output logic level_tick
);
  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  logic dck_d_r;
  logic di_d_r;
  logic lck_d_r;
  logic dck_edge;
  logic di_rise;
  logic di_fall;
  logic lck_edge;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dck_d_r <= 1'b0;
      di_d_r <= 1'b0;
      lck_d_r <= 1'b0;
    end
    else
    begin
      dck_d_r <= link.shift_clock_in;
      di_d_r <= link.serial_in;
      lck_d_r <= level_clock_in;
    end
  end

  assign dck_edge = link.shift_clock_in ^ dck_d_r; // RL1
  assign di_rise = link.serial_in & ~di_d_r;
  assign di_fall = ~link.serial_in & di_d_r;
  assign lck_edge = level_clock_in ^ lck_d_r;

  // ----------------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------------
  logic [`LGSF_FRAME_BITS-1:0] shift_r;
  logic out_bit_r;
  logic [`LGSF_CNT_W-1:0] bit_cnt_r;
  logic full;
  logic arm;
  lgsf_pkg::lgsf_dev_st_t state_r;

  assign full = (bit_cnt_r == `LGSF_CNT_W'(`LGSF_FRAME_BITS));

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_r <= '0;
      out_bit_r <= 1'b0;
    end
    else if (dck_edge)
    begin
      shift_r <= {shift_r[`LGSF_FRAME_BITS-2:0], link.serial_in}; // RL1 RL2 RL4
      out_bit_r <= shift_r[`LGSF_FRAME_BITS-1]; // RL3
    end
  end

  // Saturates: in a cascade more than one frame passes through
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      bit_cnt_r <= '0;
    else if (arm)
      bit_cnt_r <= '0;
    else if (dck_edge && !full)
      bit_cnt_r <= bit_cnt_r + `LGSF_CNT_W'(1);
  end

  // ----------------------------------------------------------------------
  // Latch sequence detection
  // ----------------------------------------------------------------------
  logic idle_expire;
  logic ret_busy;
  logic [2:0] fall_cnt_r;
  logic latch_hit;

  // Reloaded on every shift clock edge, so it only expires after a quiet spell
  lgsf_timer #(.W(`LGSF_TIMER_W)) u_idle (
    .mclk(mclk),
    .resetn(resetn),
    .load(dck_edge),
    .value(`LGSF_TIMER_W'(START_CYC)),
    .busy(),
    .expire(idle_expire)
  );

  assign arm = (state_r == lgsf_pkg::DEV_SHIFT) && idle_expire && full && !dck_edge; // RL20

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state_r <= lgsf_pkg::DEV_SHIFT;
    else
    begin
      case (state_r)
        lgsf_pkg::DEV_SHIFT:
          if (arm)
            state_r <= lgsf_pkg::DEV_ARMED;
        lgsf_pkg::DEV_ARMED:
          if (dck_edge)
            state_r <= lgsf_pkg::DEV_SHIFT;
        default:
          state_r <= lgsf_pkg::DEV_SHIFT;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      fall_cnt_r <= '0;
    else if (arm)
      fall_cnt_r <= '0;
    else if ((state_r == lgsf_pkg::DEV_ARMED) && di_fall && (fall_cnt_r != 3'(`LGSF_LATCH_PULSES)))
      fall_cnt_r <= fall_cnt_r + 3'h1;
  end

  assign latch_hit = (state_r == lgsf_pkg::DEV_ARMED) && di_fall && !dck_edge
                     && (fall_cnt_r == 3'(`LGSF_LATCH_FALL - 1)); // RL21

  // ----------------------------------------------------------------------
  // Holding latch
  // ----------------------------------------------------------------------
  logic [`LGSF_WORD_BITS-1:0] ctrl_r;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r <= `LGSF_CTRL_RST;
      levels <= '0;
      latch_load <= 1'b0;
    end
    else
    begin
      latch_load <= latch_hit;
      if (latch_hit)
      begin
        ctrl_r <= shift_r[`LGSF_CTRL_MSB:`LGSF_CTRL_LSB]; // RL2 RL5 RL23
        levels <= shift_r[`LGSF_LEVEL_MSB:0]; // RL16 RL23
      end
    end
  end

  // ----------------------------------------------------------------------
  // Cascade output
  // ----------------------------------------------------------------------
  // Clock and data go out in the same cycle, both two cycles after the input shift clock edge
  lgsf_timer #(.W(`LGSF_TIMER_W)) u_retime (
    .mclk(mclk),
    .resetn(resetn),
    .load((state_r == lgsf_pkg::DEV_ARMED) && di_rise),
    .value(`LGSF_TIMER_W'(RETIME_CYC)),
    .busy(ret_busy),
    .expire()
  );

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      link.serial_out <= 1'b0;
      link.shift_clock_out <= 1'b0;
    end
    else
    begin
      link.shift_clock_out <= dck_d_r; // RL3
      if (state_r == lgsf_pkg::DEV_ARMED)
        link.serial_out <= ret_busy; // RL22
      else
        link.serial_out <= out_bit_r; // RL3
    end
  end

  // ----------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      control_word <= `LGSF_CTRL_RST;
      edge_fast <= 1'b0;
      resolution_sel <= `LGSF_RES_8;
      level_depth <= `LGSF_DEPTH_8;
      prescale_shift <= `LGSF_SH_DIV1;
      adaptive_density_waveform <= 1'b0;
      segmented_pulse_waveform <= 1'b1;
      ext_clock_sel <= 1'b0;
      output_inverted <= 1'b0;
      counter_restart <= 1'b0;
      single_frame <= 1'b0;
    end
    else
    begin
      control_word <= ctrl_r;
      edge_fast <= ctrl_r[`LGSF_F_EDGE]; // RL7
      resolution_sel <= ctrl_r[`LGSF_F_RES_MSB:`LGSF_F_RES_LSB];
      case (ctrl_r[`LGSF_F_RES_MSB:`LGSF_F_RES_LSB]) // RL8
        `LGSF_RES_8: level_depth <= `LGSF_DEPTH_8;
        `LGSF_RES_12: level_depth <= `LGSF_DEPTH_12;
        `LGSF_RES_14: level_depth <= `LGSF_DEPTH_14;
        default: level_depth <= `LGSF_DEPTH_16;
      endcase
      case (ctrl_r[`LGSF_F_PRE_MSB:`LGSF_F_PRE_LSB]) // RL9
        `LGSF_PRE_DIV1: prescale_shift <= `LGSF_SH_DIV1;
        `LGSF_PRE_DIV2: prescale_shift <= `LGSF_SH_DIV2;
        `LGSF_PRE_DIV4: prescale_shift <= `LGSF_SH_DIV4;
        `LGSF_PRE_DIV8: prescale_shift <= `LGSF_SH_DIV8;
        `LGSF_PRE_DIV16: prescale_shift <= `LGSF_SH_DIV16;
        `LGSF_PRE_DIV64: prescale_shift <= `LGSF_SH_DIV64;
        `LGSF_PRE_DIV128: prescale_shift <= `LGSF_SH_DIV128;
        default: prescale_shift <= `LGSF_SH_DIV256;
      endcase
      adaptive_density_waveform <= ctrl_r[`LGSF_F_WAVE]; // RL11
      segmented_pulse_waveform <= ~ctrl_r[`LGSF_F_WAVE]; // RL11
      ext_clock_sel <= ctrl_r[`LGSF_F_SRC]; // RL12
      output_inverted <= ctrl_r[`LGSF_F_SENSE]; // RL13
      // Illegal combinations fall back to the permitted mode
      counter_restart <= ctrl_r[`LGSF_F_RESTART] & ctrl_r[`LGSF_F_SRC]; // RL14
      single_frame <= ctrl_r[`LGSF_F_SINGLE] & ctrl_r[`LGSF_F_RESTART] & ctrl_r[`LGSF_F_SRC]; // RL15
    end
  end

  // ----------------------------------------------------------------------
  // Grayscale clock source and prescaler
  // ----------------------------------------------------------------------
  logic [7:0] osc_cnt_r;
  logic osc_tick;
  logic [7:0] pre_cnt_r;
  logic [7:0] pre_mask;
  logic int_tick;
  logic int_clk_r;

  assign osc_tick = (osc_cnt_r == 8'(OSC_HALF_CYC - 1));
  assign pre_mask = 8'((9'h001 << prescale_shift) - 9'h001);
  assign int_tick = osc_tick && ((pre_cnt_r & pre_mask) == 8'h00); // RL9

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_cnt_r <= 8'h00;
      pre_cnt_r <= 8'h00;
      int_clk_r <= 1'b0;
    end
    else
    begin
      osc_cnt_r <= osc_tick ? 8'h00 : osc_cnt_r + 8'h01;
      if (osc_tick)
        pre_cnt_r <= pre_cnt_r + 8'h01;
      if (int_tick)
        int_clk_r <= ~int_clk_r;
    end
  end

  // Prescaler is bypassed entirely on the external source
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_clock_out <= 1'b0;
      level_tick <= 1'b0;
    end
    else if (ext_clock_sel)
    begin
      level_clock_out <= level_clock_in; // RL12
      level_tick <= lck_edge;
    end
    else
    begin
      level_clock_out <= int_clk_r;
      level_tick <= int_tick;
    end
  end
endmodule : lgsf_device

/* lgsf_host.sv */
// Sender end: shifts one 208-bit frame MSB first on both clock edges,
// then runs the quiet interval and the four-pulse latch sequence.
// Assumes the user holds frame stable while start is accepted.
`timescale 1ns/1ps
`include "lgsf_map.svh"
module lgsf_host #(
  parameter int HALF_CYC = `LGSF_DCK_HALF_NS / `LGSF_CLK_PERIOD_NS,
  parameter int START_CYC = (`LGSF_START_TIME_US * `LGSF_NS_PER_US) / `LGSF_CLK_PERIOD_NS + 1,
  parameter int HI_CYC = `LGSF_PULSE_HI_NS / `LGSF_CLK_PERIOD_NS + 1,
  parameter int LO_CYC = `LGSF_PULSE_LO_NS / `LGSF_CLK_PERIOD_NS + 1,
  parameter int CASCADE = 1,
  parameter int STOP_CYC = (`LGSF_STOP_BASE_NS + CASCADE * `LGSF_STOP_PER_DEV_NS) / `LGSF_CLK_PERIOD_NS + 1
) (
  input wire logic mclk,
  input wire logic resetn,
  lgsf_link_if.host link,
  input wire logic start,
  input wire logic [`LGSF_FRAME_BITS-1:0] frame,
  output logic ready,
  output logic done
);
  localparam int STOP_LEN = (STOP_CYC > LO_CYC) ? STOP_CYC : LO_CYC;

  lgsf_pkg::lgsf_host_st_t state_r;
  logic [`LGSF_FRAME_BITS-1:0] tx_r;
  logic [`LGSF_FRAME_BITS-1:0] clean;
  logic [`LGSF_WORD_BITS-1:0] ctrl;
  logic [`LGSF_WORD_BITS-1:0] mask;
  logic [`LGSF_CNT_W-1:0] bit_cnt_r;
  logic [2:0] pulse_cnt_r;
  logic tmr_load_r;
  logic [`LGSF_TIMER_W-1:0] tmr_val_r;
  logic tmr_exp;

  // ----------------------------------------------------------------------
  // Frame cleanup
  // ----------------------------------------------------------------------
  always_comb
  begin
    ctrl = frame[`LGSF_CTRL_MSB:`LGSF_CTRL_LSB];
    ctrl[`LGSF_F_UNUSED_MSB:`LGSF_F_UNUSED_LSB] = '0; // RL6
    if (ctrl[`LGSF_F_SRC])
      ctrl[`LGSF_F_PRE_MSB:`LGSF_F_PRE_LSB] = `LGSF_PRE_DIV1; // RL10
    case (ctrl[`LGSF_F_RES_MSB:`LGSF_F_RES_LSB])
      `LGSF_RES_8: mask = `LGSF_MASK_8;
      `LGSF_RES_12: mask = `LGSF_MASK_12;
      `LGSF_RES_14: mask = `LGSF_MASK_14;
      default: mask = `LGSF_MASK_16;
    endcase
    clean = '0;
    clean[`LGSF_CTRL_MSB:`LGSF_CTRL_LSB] = ctrl; // RL5
    for (int i = 0; i < `LGSF_CHANNELS; i++)
      clean[i*`LGSF_WORD_BITS +: `LGSF_WORD_BITS] = frame[i*`LGSF_WORD_BITS +: `LGSF_WORD_BITS] & mask; // RL16 RL17
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Timer load and expiry are both registered, so each wait is two cycles longer than its count
  lgsf_timer #(.W(`LGSF_TIMER_W)) u_tmr (
    .mclk(mclk),
    .resetn(resetn),
    .load(tmr_load_r),
    .value(tmr_val_r),
    .busy(),
    .expire(tmr_exp)
  );

  assign ready = (state_r == lgsf_pkg::HOST_IDLE);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= lgsf_pkg::HOST_IDLE;
      tx_r <= '0;
      bit_cnt_r <= '0;
      pulse_cnt_r <= '0;
      tmr_load_r <= 1'b0;
      tmr_val_r <= '0;
      done <= 1'b0;
      link.shift_clock_in <= 1'b0;
      link.serial_in <= 1'b0;
    end
    else
    begin
      tmr_load_r <= 1'b0;
      done <= 1'b0;
      case (state_r)
        lgsf_pkg::HOST_IDLE:
          if (start)
          begin
            tx_r <= clean; // RL4
            bit_cnt_r <= '0;
            tmr_load_r <= 1'b1;
            tmr_val_r <= `LGSF_TIMER_W'(HALF_CYC);
            state_r <= lgsf_pkg::HOST_BIT;
          end
        lgsf_pkg::HOST_BIT:
        begin
          // Data follows one cycle after the clock edge, giving hold time
          link.serial_in <= tx_r[`LGSF_FRAME_BITS-1]; // RL5 RL16
          if (tmr_exp)
          begin
            link.shift_clock_in <= ~link.shift_clock_in; // RL1
            tx_r <= {tx_r[`LGSF_FRAME_BITS-2:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + `LGSF_CNT_W'(1);
            tmr_load_r <= 1'b1;
            if (bit_cnt_r == `LGSF_CNT_W'(`LGSF_FRAME_BITS - 1))
            begin
              tmr_val_r <= `LGSF_TIMER_W'(START_CYC); // RL20
              state_r <= lgsf_pkg::HOST_START;
            end
            else
              tmr_val_r <= `LGSF_TIMER_W'(HALF_CYC);
          end
        end
        lgsf_pkg::HOST_START:
        begin
          link.serial_in <= 1'b0;
          if (tmr_exp)
          begin
            pulse_cnt_r <= '0;
            link.serial_in <= 1'b1;
            tmr_load_r <= 1'b1;
            tmr_val_r <= `LGSF_TIMER_W'(HI_CYC); // RL18
            state_r <= lgsf_pkg::HOST_HI;
          end
        end
        lgsf_pkg::HOST_HI:
          if (tmr_exp)
          begin
            link.serial_in <= 1'b0;
            pulse_cnt_r <= pulse_cnt_r + 3'h1;
            tmr_load_r <= 1'b1;
            if (pulse_cnt_r == 3'(`LGSF_LATCH_PULSES - 1)) // RL21
            begin
              tmr_val_r <= `LGSF_TIMER_W'(STOP_LEN); // RL19
              state_r <= lgsf_pkg::HOST_STOP;
            end
            else
            begin
              tmr_val_r <= `LGSF_TIMER_W'(LO_CYC); // RL18
              state_r <= lgsf_pkg::HOST_LO;
            end
          end
        lgsf_pkg::HOST_LO:
          if (tmr_exp)
          begin
            link.serial_in <= 1'b1;
            tmr_load_r <= 1'b1;
            tmr_val_r <= `LGSF_TIMER_W'(HI_CYC);
            state_r <= lgsf_pkg::HOST_HI;
          end
        lgsf_pkg::HOST_STOP:
          if (tmr_exp)
          begin
            done <= 1'b1;
            state_r <= lgsf_pkg::HOST_IDLE;
          end
        default:
          state_r <= lgsf_pkg::HOST_IDLE;
      endcase
    end
  end
endmodule : lgsf_host

/* lgsf_link_if.sv */
// Serial link between a frame sender and one LED driver front end.
// Assumes both ends run on the same mclk; the testbench joins them.
`timescale 1ns/1ps
interface lgsf_link_if;
  logic shift_clock_in;
  logic serial_in;
  logic serial_out;
  logic shift_clock_out;

  modport host (
    output shift_clock_in,
    output serial_in,
    input serial_out,
    input shift_clock_out
  );

  modport dev (
    input shift_clock_in,
    input serial_in,
    output serial_out,
    output shift_clock_out
  );
endinterface : lgsf_link_if

/* lgsf_link_properties.sv */
// Concurrent checks on the sender to driver serial link.
// Assumes one mclk domain; placed beside the link interface.
`timescale 1ns/1ps
module lgsf_link_properties #(
  parameter int START_CYC = 40
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic shift_clock_in,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic shift_clock_out
);
  logic sck_d_r;
  logic [7:0] quiet_r;
  logic q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Quiet time since the last shift edge
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_d_r <= 1'b0;
      quiet_r <= 8'h00;
    end
    else
    begin
      sck_d_r <= shift_clock_in;
      if (shift_clock_in != sck_d_r)
        quiet_r <= 8'h00;
      else if (quiet_r != 8'hff)
        quiet_r <= quiet_r + 8'h01;
    end
  end
  // Margin of a few cycles, the exact arming offset is not fixed
  assign q = (int'(quiet_r) >= START_CYC - 4);
  a_clock_out_copy: assert property ($past(shift_clock_in, 2) == shift_clock_out)
    else $error("shift clock out is not a two cycle copy");
  a_data_settled: assert property ($changed(shift_clock_in) |-> $stable(serial_in))
    else $error("data moved on a shift edge");
  a_edge_spacing: assert property ($changed(shift_clock_in) |=> $stable(shift_clock_in)[*5])
    else $error("shift edges too close");
  a_out_on_edge: assert property ($changed(serial_out) && !q |-> $past(shift_clock_in, 2) != $past(shift_clock_in, 3))
    else $error("serial out moved without a shift edge");
  a_retime_width: assert property ($rose(serial_out) && q |-> serial_out[*8] ##1 serial_out ##1 !serial_out)
    else $error("retimed pulse width wrong");
  a_latch_high: assert property ($rose(serial_in) && q |-> serial_in[*8] ##1 serial_in[*2] ##1 !serial_in)
    else $error("latch pulse high time wrong");
  a_latch_low: assert property ($fell(serial_in) && q |-> !serial_in[*8] ##1 !serial_in[*8] ##1 !serial_in[*8])
    else $error("latch pulse low time too short");
  a_quiet_first: assert property ($rose(serial_in) && quiet_r > 8'h08 |-> q)
    else $error("latch pulse before quiet interval");
  c_latch_pulse: cover property ($rose(serial_in) && q);
  c_retime: cover property ($rose(serial_out) && q);
  c_shift_edge: cover property ($changed(shift_clock_in) ##2 $changed(serial_out));
endmodule : lgsf_link_properties

/* lgsf_map.svh */
// Named constants for the LED grayscale serial front end: frame layout,
// control word fields, encodings and timing figures.
// Assumes a single 100 MHz system clock; included by the sender, driver and timer modules.
`ifndef LGSF_MAP_SVH
`define LGSF_MAP_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define LGSF_FRAME_BITS 208
`define LGSF_WORD_BITS 16
`define LGSF_CHANNELS 12
`define LGSF_CTRL_MSB 207
`define LGSF_CTRL_LSB 192
`define LGSF_LEVEL_MSB 191
`define LGSF_CNT_W 8
`define LGSF_CTRL_RST 16'h0000

// ----------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------
`define LGSF_F_UNUSED_MSB 15
`define LGSF_F_UNUSED_LSB 11
`define LGSF_F_EDGE 10
`define LGSF_F_RES_MSB 9
`define LGSF_F_RES_LSB 8
`define LGSF_F_PRE_MSB 7
`define LGSF_F_PRE_LSB 5
`define LGSF_F_WAVE 4
`define LGSF_F_SRC 3
`define LGSF_F_SENSE 2
`define LGSF_F_RESTART 1
`define LGSF_F_SINGLE 0

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define LGSF_RES_8 2'h0
`define LGSF_RES_12 2'h1
`define LGSF_RES_14 2'h2
`define LGSF_RES_16 2'h3
`define LGSF_DEPTH_8 5'h08
`define LGSF_DEPTH_12 5'h0c
`define LGSF_DEPTH_14 5'h0e
`define LGSF_DEPTH_16 5'h10
`define LGSF_MASK_8 16'h00ff
`define LGSF_MASK_12 16'h0fff
`define LGSF_MASK_14 16'h3fff
`define LGSF_MASK_16 16'hffff
`define LGSF_PRE_DIV1 3'h0
`define LGSF_PRE_DIV2 3'h1
`define LGSF_PRE_DIV4 3'h2
`define LGSF_PRE_DIV8 3'h3
`define LGSF_PRE_DIV16 3'h4
`define LGSF_PRE_DIV64 3'h5
`define LGSF_PRE_DIV128 3'h6
`define LGSF_PRE_DIV256 3'h7
`define LGSF_SH_DIV1 4'h0
`define LGSF_SH_DIV2 4'h1
`define LGSF_SH_DIV4 4'h2
`define LGSF_SH_DIV8 4'h3
`define LGSF_SH_DIV16 4'h4
`define LGSF_SH_DIV64 4'h6
`define LGSF_SH_DIV128 4'h7
`define LGSF_SH_DIV256 4'h8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LGSF_CLK_PERIOD_NS 10
`define LGSF_NS_PER_US 1000
`define LGSF_START_TIME_US 220
`define LGSF_RETIME_NS 90
`define LGSF_PULSE_HI_NS 70
`define LGSF_PULSE_LO_NS 230
`define LGSF_STOP_BASE_NS 200
`define LGSF_STOP_PER_DEV_NS 10
`define LGSF_DCK_HALF_NS 50
`define LGSF_LATCH_PULSES 4
`define LGSF_LATCH_FALL 2
`define LGSF_OSC_HALF_CYC 6
`define LGSF_TIMER_W 16

`endif

/* lgsf_pkg.sv */
// Types shared by both ends of the LED grayscale serial link.
// Assumes lgsf_map.svh supplies all numeric constants.
package lgsf_pkg;

  typedef enum logic [5:0] {
    HOST_IDLE = 6'b000001,
    HOST_BIT = 6'b000010,
    HOST_START = 6'b000100,
    HOST_HI = 6'b001000,
    HOST_LO = 6'b010000,
    HOST_STOP = 6'b100000
  } lgsf_host_st_t;

  typedef enum logic [1:0] {
    DEV_SHIFT = 2'b01,
    DEV_ARMED = 2'b10
  } lgsf_dev_st_t;

endpackage : lgsf_pkg

/* lgsf_timer.sv */
// Loadable down counter with a one-cycle expiry pulse.
// Assumes load and value are synchronous to mclk.
`timescale 1ns/1ps
`include "lgsf_map.svh"
module lgsf_timer #(
  parameter int W = `LGSF_TIMER_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic busy,
  output logic expire
);
  logic [W-1:0] count_r;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= '0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= !load && (count_r == W'(1));
      if (load)
        count_r <= value;
      else if (count_r != '0)
        count_r <= count_r - W'(1);
    end
  end

  assign busy = (count_r != '0);
endmodule : lgsf_timer
